// [bit_sync.sv]
// two-flop synchroniser for a group of level signals
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,  // destination clock
    input  wire logic         rst,  // synchronous reset
    input  wire logic [W-1:0] d,    // asynchronous levels
    output logic      [W-1:0] q     // synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // bit_sync
`default_nettype wire

// [i2c_host.sv]
// two-wire bus host model: drives the serial clock and pulls the data line
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
    output logic      scl,      // serial clock, high while idle
    output logic      sda_low,  // pulls the data line low
    input  wire logic sda       // resolved data line
);
    int slow_ns = 0;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_out(input logic b);
        #(12 + slow_ns) sda_low = ~b;
        #12 scl = 1'b1;
        #24 scl = 1'b0;
    endtask

    task automatic bit_in(output logic b);
        #(12 + slow_ns) sda_low = 1'b0;
        #12 scl = 1'b1;
        #12 b = sda;
        #12 scl = 1'b0;
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        #12 sda_low = 1'b0;
        #12 scl = 1'b1;
        #24 sda_low = 1'b1;
        #24 scl = 1'b0;
    endtask

    // clock stays high afterwards, bus idle
    task automatic stop();
        #12 sda_low = 1'b1;
        #12 scl = 1'b1;
        #24 sda_low = 1'b0;
        #24;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    // last byte of a read is answered with a high bit
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule // i2c_host
`default_nettype wire

// [link_capture.sv]
// serial clock domain: samples the data line on each rising serial clock
`timescale 1ns/10ps
`default_nettype none
module link_capture (
    input  wire logic scl,      // serial clock from host
    input  wire logic rst,      // reset, constants only
    input  wire logic sda_i,    // data line level
    output logic      bit_r,    // last sampled bit, stable for a period
    output logic      tog_r     // flips once per sampled bit
);
    // serial clock may stand still, so reset must not wait for an edge
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            bit_r <= 1'b0;
            tog_r <= 1'b0;
        end else begin
            bit_r <= sda_i;
            tog_r <= ~tog_r;
        end
    end
endmodule // link_capture
`default_nettype wire

// [protect_pkg.sv]
// constants and types shared by the write-protection block
// Behaviour
// - device address: type nibble, two strap bits, don't-care bit, read/write bit.
// - large array variant ignores the lower strap bit for register access.
// - word address top two bits 11 select the register; other six ignored.
// - more than one data byte aborts the write; register unchanged.
// - bit 3 enables software protection; zero means nothing protected.
// - bits 2:1 pick upper quarter, half, three quarters or whole array.
// - small array ranges start at 180h, 100h, 080h, 000h up to 1FFh.
// - large array ranges start at 300h, 200h, 100h, 000h up to 3FFh.
// - once lock bit is one, no further register write cycle runs.
// - upper nibble 4h unlocked or 6h locking; bit 5 must equal lock bit.
// - register read needs a random read; current address read gets nothing.
// - register read returns zero in bits 7:4 and stored fields below.
// - register starts with enable 0, block select 00, lock 0.
// - protected writes are acknowledged but start no write cycle.
// - register update is one byte ended by stop, then a timed cycle.
package protect_pkg;

    typedef struct packed {
        logic       soft_protect_enable;   // bit 3
        logic [1:0] protect_block_select;  // bits 2:1
        logic       protect_config_lock;   // bit 0
    } protect_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WORD, ST_DATA, ST_READ, ST_WAIT
    } link_state_t;

    localparam protect_cfg_t CFG_RESET    = 4'h0;
    localparam logic [1:0]   REG_SEL      = 2'h3;
    localparam logic [3:0]   NIBBLE_KEEP  = 4'h4;
    localparam logic [3:0]   NIBBLE_LOCK  = 4'h6;
    localparam logic [3:0]   READ_PAD     = 4'h0;
    localparam int           BIT_LAST     = 7;
    localparam logic [3:0]   BIT_ACK      = 4'h8;

    localparam logic [9:0]   SMALL_MASK   = 10'h1FF;
    localparam logic [9:0]   LARGE_MASK   = 10'h3FF;
    localparam logic [9:0]   SMALL_QUART  = 10'h180;
    localparam logic [9:0]   SMALL_HALF   = 10'h100;
    localparam logic [9:0]   SMALL_3QUART = 10'h080;
    localparam logic [9:0]   LARGE_QUART  = 10'h300;
    localparam logic [9:0]   LARGE_HALF   = 10'h200;
    localparam logic [9:0]   LARGE_3QUART = 10'h100;
    localparam logic [9:0]   FULL_START   = 10'h000;

    localparam int           CLK_PERIOD_PS = 4000;
    localparam longint       T_WR_PS       = 64'd5000000000;
    // longest time: round down
    localparam int           WR_CYCLES     = int'(T_WR_PS / CLK_PERIOD_PS);
    localparam int           WR_CNT_W      = 21;

endpackage

// [soft_protect.sv]
// protection register, two-wire slave engine and protected range decode
`timescale 1ns/10ps
`default_nettype none
module soft_protect #(
    // arbitrary type nibble, stands in for the maker's code
    parameter logic [3:0] TYPE_ID   = 4'h5,
    parameter logic [1:0] HW_ADDR   = 2'h0,   // strap bits A2, A1
    parameter bit         LARGE     = 1'b0,   // 1024-byte variant
    parameter int         WR_CYCLES = protect_pkg::WR_CYCLES
) (
    input  wire logic                      clk,          // core clock
    input  wire logic                      rst,          // sync reset
    input  wire logic                      scl,          // serial clock
    input  wire logic                      sda_i,        // data line in
    output logic                           sda_o,        // data line out
    output logic                           sda_oe,       // pull low enable
    input  wire logic                      array_wr_req, // array write ask
    input  wire logic [9:0]                array_wr_addr,// its word address
    output logic                           array_wr_grant,// write allowed
    output logic                           array_wr_block,// write refused
    output logic                           protect_on,   // range active
    output logic [9:0]                     protect_start,// first protected
    output logic                           busy,         // write cycle
    output protect_pkg::protect_cfg_t      cfg_out       // stored register
);

    localparam int WR_CNT_W   = protect_pkg::WR_CNT_W;
    localparam int WR_CNT_MSB = WR_CNT_W - 1;
    // cycle count minus one, cut to the counter width on purpose
    localparam logic [WR_CNT_MSB:0] WR_LOAD = WR_CNT_W'(WR_CYCLES - 1);

    protect_pkg::protect_cfg_t  cfg_r;
    protect_pkg::protect_cfg_t  pend_r;
    protect_pkg::link_state_t   state_r;
    logic [2:0]                 sync_q;
    logic                       cap_bit;
    logic                       cap_tog;
    logic                       scl_q;
    logic                       sda_q;
    logic                       tog_q;
    logic                       start_evt;
    logic                       stop_evt;
    logic                       fall_evt;
    logic                       rise_evt;
    logic [3:0]                 bit_cnt_r;
    logic [6:0]                 rx_r;
    logic [7:0]                 byte_in;
    logic [7:0]                 tx_r;
    logic [7:0]                 data_r;
    logic [1:0]                 wr_cnt_r;
    logic                       ack_pend_r;
    logic                       host_chk_r;
    logic                       ptr_cfg_r;
    logic                       dev_match;
    logic                       pat_ok;
    logic                       wr_ok;
    logic [WR_CNT_MSB:0]        wr_cnt_cyc_r;
    logic [9:0]                 start_nxt;
    logic [9:0]                 addr_m;
    logic                       hit;

    link_capture u_link_capture (
        .scl   (scl),
        .rst   (rst),
        .sda_i (sda_i),
        .bit_r (cap_bit),
        .tog_r (cap_tog)
    );

    bit_sync #(.W(3)) u_bit_sync (
        .clk (clk),
        .rst (rst),
        .d   ({scl, sda_i, cap_tog}),
        .q   (sync_q)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            // match the synchroniser's reset level, no false edge after reset
            scl_q <= 1'b0;
            sda_q <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            scl_q <= sync_q[2];
            sda_q <= sync_q[1];
            tog_q <= sync_q[0];
        end
    end

    assign start_evt = sync_q[2] & scl_q & sda_q & ~sync_q[1];
    assign stop_evt  = sync_q[2] & scl_q & ~sda_q & sync_q[1];
    assign fall_evt  = scl_q & ~sync_q[2];
    assign rise_evt  = sync_q[0] ^ tog_q;
    assign byte_in   = {rx_r, cap_bit};

    // strap bit A1 is ignored on the large variant
    assign dev_match = (byte_in[7:4] == TYPE_ID)
                     & (byte_in[3] == HW_ADDR[1])
                     & (LARGE | (byte_in[2] == HW_ADDR[0]));

    // fixed nibble pattern, bit 5 must match lock bit
    assign pat_ok = (data_r[7:4] == protect_pkg::NIBBLE_KEEP
                     && !data_r[0])
                  || (data_r[7:4] == protect_pkg::NIBBLE_LOCK
                     && data_r[0]);

    assign wr_ok = stop_evt && state_r == protect_pkg::ST_DATA
                 && wr_cnt_r == 2'h1
                 && !cfg_r.protect_config_lock
                 && pat_ok && !busy;

    // bit and byte engine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= protect_pkg::ST_IDLE;
            bit_cnt_r  <= 4'h0;
            rx_r       <= 7'h00;
            tx_r       <= 8'h00;
            data_r     <= 8'h00;
            wr_cnt_r   <= 2'h0;
            ack_pend_r <= 1'b0;
            host_chk_r <= 1'b0;
            ptr_cfg_r  <= 1'b0;
        end else if (start_evt) begin
            state_r    <= protect_pkg::ST_DEV;
            bit_cnt_r  <= 4'h0;
            wr_cnt_r   <= 2'h0;
            ack_pend_r <= 1'b0;
        end else if (stop_evt) begin
            state_r    <= protect_pkg::ST_IDLE;
            bit_cnt_r  <= 4'h0;
            ack_pend_r <= 1'b0;
            ptr_cfg_r  <= 1'b0;
        end else if (rise_evt && state_r != protect_pkg::ST_IDLE
                     && state_r != protect_pkg::ST_WAIT) begin
            if (bit_cnt_r == protect_pkg::BIT_ACK) begin
                bit_cnt_r <= 4'h0;
                if (state_r == protect_pkg::ST_READ) begin
                    // host answer; high means no more data
                    if (host_chk_r && cap_bit) begin
                        state_r <= protect_pkg::ST_WAIT;
                    end
                    host_chk_r <= 1'b1;
                    tx_r <= {protect_pkg::READ_PAD, cfg_r};
                end
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                rx_r      <= byte_in[6:0];
                tx_r      <= {tx_r[6:0], 1'b0};
                if (bit_cnt_r == 4'(protect_pkg::BIT_LAST)) begin
                    case (state_r)
                        protect_pkg::ST_DEV: begin
                            if (!dev_match || busy) begin
                                ack_pend_r <= 1'b0;
                                state_r    <= protect_pkg::ST_WAIT;
                            end else if (byte_in[0]) begin
                                // read only after a dummy write set pointer
                                ack_pend_r <= ptr_cfg_r;
                                host_chk_r <= 1'b0;
                                state_r    <= ptr_cfg_r ?
                                              protect_pkg::ST_READ :
                                              protect_pkg::ST_WAIT;
                            end else begin
                                ack_pend_r <= 1'b1;
                                ptr_cfg_r  <= 1'b0;
                                state_r    <= protect_pkg::ST_WORD;
                            end
                        end
                        protect_pkg::ST_WORD: begin
                            // low six bits are don't-care
                            if (byte_in[7:6] == protect_pkg::REG_SEL) begin
                                ack_pend_r <= 1'b1;
                                ptr_cfg_r  <= 1'b1;
                                state_r    <= protect_pkg::ST_DATA;
                            end else begin
                                ack_pend_r <= 1'b0;
                                state_r    <= protect_pkg::ST_WAIT;
                            end
                        end
                        protect_pkg::ST_DATA: begin
                            // every byte acknowledged, extra ones spoil it
                            ack_pend_r <= 1'b1;
                            if (wr_cnt_r == 2'h0) begin
                                data_r <= byte_in;
                            end
                            if (wr_cnt_r != 2'h2) begin
                                wr_cnt_r <= wr_cnt_r + 2'h1;
                            end
                        end
                        protect_pkg::ST_READ: begin
                            ack_pend_r <= 1'b0;
                        end
                        default: begin
                            ack_pend_r <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // data line drive, changed while the serial clock is low, and released at start or stop while it is high
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_oe <= 1'b0;
            sda_o  <= 1'b0;
        end else if (start_evt || stop_evt) begin
            sda_oe <= 1'b0;
        end else if (fall_evt) begin
            if (bit_cnt_r == protect_pkg::BIT_ACK) begin
                sda_oe <= ack_pend_r;
            end else if (state_r == protect_pkg::ST_READ) begin
                sda_oe <= ~tx_r[7];
            end else begin
                sda_oe <= 1'b0;
            end
            sda_o <= 1'b0;
        end
    end

    // self-timed register write cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r        <= protect_pkg::CFG_RESET;
            pend_r       <= protect_pkg::CFG_RESET;
            busy         <= 1'b0;
            wr_cnt_cyc_r <= '0;
        end else if (wr_ok) begin
            busy         <= 1'b1;
            pend_r       <= data_r[3:0];
            wr_cnt_cyc_r <= WR_LOAD;
        end else if (busy) begin
            if (wr_cnt_cyc_r == '0) begin
                busy  <= 1'b0;
                cfg_r <= pend_r;
            end else begin
                wr_cnt_cyc_r <= wr_cnt_cyc_r - 1'b1;
            end
        end
    end

    // first protected address for the current setting
    always_comb begin
        start_nxt = protect_pkg::FULL_START;
        case (cfg_r.protect_block_select)
            2'h0: start_nxt = LARGE ? protect_pkg::LARGE_QUART
                                    : protect_pkg::SMALL_QUART;
            2'h1: start_nxt = LARGE ? protect_pkg::LARGE_HALF
                                    : protect_pkg::SMALL_HALF;
            2'h2: start_nxt = LARGE ? protect_pkg::LARGE_3QUART
                                    : protect_pkg::SMALL_3QUART;
            default: start_nxt = protect_pkg::FULL_START;
        endcase
    end

    assign addr_m = array_wr_addr & (LARGE ? protect_pkg::LARGE_MASK
                                           : protect_pkg::SMALL_MASK);
    assign hit = cfg_r.soft_protect_enable && addr_m >= start_nxt;

    always_ff @(posedge clk) begin
        if (rst) begin
            protect_on     <= 1'b0;
            protect_start  <= protect_pkg::FULL_START;
            array_wr_grant <= 1'b0;
            array_wr_block <= 1'b0;
            cfg_out        <= protect_pkg::CFG_RESET;
        end else begin
            protect_on     <= cfg_r.soft_protect_enable;
            protect_start  <= start_nxt;
            array_wr_grant <= array_wr_req & ~hit;
            array_wr_block <= array_wr_req & hit;
            cfg_out        <= cfg_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_reg_write;
        stop_evt && state_r == protect_pkg::ST_DATA && !busy;
    endsequence

    sequence s_cycle_start;
        busy ##1 busy;
    endsequence

    property p_reset_value;
        $fell(rst) |-> cfg_r == protect_pkg::CFG_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("register not at delivered value after reset");

    property p_lock_hold;
        cfg_r.protect_config_lock |=> !busy && $stable(cfg_r);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked register changed or write cycle ran");

    property p_extra_bytes;
        s_reg_write and wr_cnt_r == 2'h2 |=> !busy;
    endproperty
    a_extra_bytes: assert property (p_extra_bytes)
        else $error("multi-byte register write started a cycle");

    property p_pattern;
        s_reg_write and !pat_ok |=> !busy;
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("bad nibble pattern started a cycle");

    property p_commit;
        s_reg_write and wr_cnt_r == 2'h1 && pat_ok
            && !cfg_r.protect_config_lock |=> s_cycle_start;
    endproperty
    a_commit: assert property (p_commit)
        else $error("valid single-byte write started no cycle");

    property p_read_pad;
        state_r == protect_pkg::ST_READ && bit_cnt_r == protect_pkg::BIT_ACK
            && rise_evt && !start_evt && !stop_evt
            |=> tx_r[7:4] == protect_pkg::READ_PAD;
    endproperty
    a_read_pad: assert property (p_read_pad)
        else $error("register read upper nibble not zero");

    property p_disabled;
        !cfg_r.soft_protect_enable && array_wr_req
            |=> array_wr_grant && !array_wr_block && !protect_on;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("write refused while protection disabled");

    property p_range;
        array_wr_req && cfg_r.soft_protect_enable && addr_m >= start_nxt
            |=> array_wr_block && !array_wr_grant;
    endproperty
    a_range: assert property (p_range)
        else $error("write inside protected range was granted");

    property p_full;
        cfg_r.soft_protect_enable && cfg_r.protect_block_select == 2'h3
            |=> protect_start == protect_pkg::FULL_START;
    endproperty
    a_full: assert property (p_full)
        else $error("whole-array setting left a gap");

endmodule // soft_protect
`default_nettype wire

// [soft_protect_test.sv]
// self-checking bench for the write-protection block
`timescale 1ns/10ps
`default_nettype none
module soft_protect_test;
    localparam logic [3:0] TID   = 4'hA; // arbitrary type nibble
    localparam logic [1:0] HWA   = 2'h2;
    localparam logic [7:0] DEV_W = {TID, HWA, 2'b00};
    localparam logic [7:0] DEV_R = {TID, HWA, 2'b01};
    localparam logic [9:0] STARTS [4] = '{10'h180, 10'h100, 10'h080, 10'h000};

    logic                      clk, rst, scl, sda, sda_low, sda_oe, ack;
    logic                      array_wr_req, array_wr_grant, array_wr_block;
    logic                      protect_on, busy, sda_o;
    logic [9:0]                array_wr_addr, protect_start;
    logic [7:0]                rd;
    protect_pkg::protect_cfg_t cfg_out;
    int                        miscompares = 0;
    int                        n_checks = 0;

    // open-drain line with pull-up
    assign sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    soft_protect #(.TYPE_ID(TID), .HW_ADDR(HWA), .LARGE(1'b0),
                   .WR_CYCLES(20)) u_soft_protect (
        .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .array_wr_req(array_wr_req),
        .array_wr_addr(array_wr_addr), .array_wr_grant(array_wr_grant),
        .array_wr_block(array_wr_block), .protect_on(protect_on),
        .protect_start(protect_start), .busy(busy), .cfg_out(cfg_out));

    i2c_host u_i2c_host (.scl(scl), .sda_low(sda_low), .sda(sda));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic addr(input logic [7:0] dev, input logic [7:0] word,
                        input logic dev_ok, input logic word_ok);
        u_i2c_host.start();
        u_i2c_host.wr_byte(dev, ack);
        chk(ack, dev_ok);
        if (dev_ok) begin
            u_i2c_host.wr_byte(word, ack);
            chk(ack, word_ok);
        end
    endtask

    // one or two data bytes, stop, then watch for the timed cycle
    task automatic reg_write(input logic [7:0] word, input logic [7:0] d,
                             input logic two, input logic cyc);
        addr(DEV_W, word, 1'b1, 1'b1);
        u_i2c_host.wr_byte(d, ack);
        chk(ack, 1'b1);
        if (two) begin
            u_i2c_host.wr_byte(d, ack);
            chk(ack, 1'b1);
        end
        u_i2c_host.stop();
        @(negedge clk);
        chk(busy, cyc);
        for (int i = 0; i < 100 && busy; i++) begin
            @(negedge clk);
        end
        chk(busy, 1'b0);
    endtask

    // dummy write with the don't-care bit set, repeated start, read
    task automatic reg_read(input logic [7:0] exp);
        addr(DEV_W | 8'h02, 8'hC0, 1'b1, 1'b1);
        u_i2c_host.start();
        u_i2c_host.wr_byte(DEV_R, ack);
        chk(ack, 1'b1);
        u_i2c_host.rd_byte(1'b1, rd);
        u_i2c_host.stop();
        chk(rd, exp);
    endtask

    task automatic arr_chk(input logic [9:0] a, input logic exp_blk);
        @(negedge clk);
        array_wr_req = 1'b1;
        array_wr_addr = a;
        @(negedge clk);
        array_wr_req = 1'b0;
        chk({array_wr_grant, array_wr_block}, {~exp_blk, exp_blk});
    endtask

    initial begin
        rst = 1'b1;
        array_wr_req = 1'b0;
        array_wr_addr = 10'h000;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        chk(cfg_out, 4'h0);
        reg_read(8'h00);
        arr_chk(10'h1FF, 1'b0);
        addr({4'h3, HWA, 2'b00}, 8'hC0, 1'b0, 1'b0);
        u_i2c_host.stop();
        addr({TID, 2'h1, 2'b00}, 8'hC0, 1'b0, 1'b0);
        u_i2c_host.stop();
        addr(DEV_W, 8'h80, 1'b1, 1'b0);
        u_i2c_host.stop();
        u_i2c_host.start();
        u_i2c_host.wr_byte(DEV_R, ack);
        chk(ack, 1'b0);
        u_i2c_host.stop();
        reg_write(8'hC0, 8'h0E, 1'b0, 1'b0);
        reg_write(8'hC0, 8'h6E, 1'b0, 1'b0);
        reg_write(8'hC0, 8'h4F, 1'b0, 1'b0);
        reg_write(8'hC0, 8'h4E, 1'b1, 1'b0);
        reg_read(8'h00);
        reg_write(8'hC5, 8'h46, 1'b0, 1'b1);
        arr_chk(10'h000, 1'b0);
        for (int b = 0; b < 4; b++) begin
            reg_write(8'hFF, {4'h4, 1'b1, b[1:0], 1'b0}, 1'b0, 1'b1);
            reg_read({4'h0, 1'b1, b[1:0], 1'b0});
            chk(protect_on, 1'b1);
            chk(protect_start, STARTS[b]);
            chk(cfg_out, {1'b1, b[1:0], 1'b0});
            arr_chk(STARTS[b], 1'b1);
            arr_chk(STARTS[b] - 10'h001, b == 3);
            arr_chk(10'h1FF, 1'b1);
        end
        u_i2c_host.slow_ns = 40;
        reg_write(8'hC0, 8'h6B, 1'b0, 1'b1);
        u_i2c_host.slow_ns = 0;
        reg_write(8'hC0, 8'h40, 1'b0, 1'b0);
        reg_read(8'h0B);
        chk(cfg_out, 4'hB);
        finish_test();
    end

    initial begin
        #300000;
        miscompares++;
        finish_test();
    end
endmodule // soft_protect_test
`default_nettype wire
